// [src/flash_host_ctrl.sv]
// AHB-Lite driven bus-cycle engine for an asynchronous NOR flash
`include "flash_ctrl_map.svh"
module flash_host_ctrl
#(
  parameter int CYCLE_CNT = `CYCLE_CNT,
  parameter int WAKE_CNT = `WAKE_CNT
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output flash_ctrl_pkg::word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [20:0] fl_addr,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_in,
  output logic fl_chip_select_first_n,
  output logic fl_chip_select_second_n,
  output logic fl_write_n,
  output logic fl_output_n,
  output logic fl_reset_powerdown_n,
  output logic fl_byte_n,
  input wire logic fl_status_output_pin
);
  import flash_ctrl_pkg::*;

  typedef enum logic [2:0] {
    st_idle,
    st_wake,
    st_setup,
    st_strobe,
    st_hold,
    st_poll
  } state_e;

  state_e state;
  op_e op;
  logic [15:0] cnt;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [31:0] ctrl;
  logic done;
  logic sts_level;
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic busy;
  logic [31:0] stat_word;
  logic [15:0] dq_level [0:0];

  assign busy = (state != st_idle);
  assign dq_level[0] = fl_dq_in;
  assign stat_word = {27'h0, ~fl_reset_powerdown_n ? 1'h0 : 1'h1,
    done, sts_level, ~busy, busy};

  pin_sync u_sts_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(fl_status_output_pin),
    .level(sts_level)
  );

  // Address phase capture, zero-wait single-word slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid <= 1'h0;
      ap_write <= 1'h0;
      ap_addr <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end
    else
    begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      unique case ({24'h0, haddr[7:0]})
        `REG_ADDR: hrdata <= {11'h0, addr};
        `REG_WDATA: hrdata <= {16'h0, wdata};
        `REG_RDATA: hrdata <= {16'h0, rdata};
        `REG_STAT: hrdata <= stat_word;
        `REG_CTRL: hrdata <= ctrl;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Register writes; bus writes to address/data ignored while busy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr <= 21'h0;
      wdata <= 16'h0;
      ctrl <= `CTRL_RESET_VAL;
    end
    else if (ap_valid && ap_write && !busy)
    begin
      if ({24'h0, ap_addr} == `REG_ADDR)
        addr <= hwdata[20:0];
      if ({24'h0, ap_addr} == `REG_WDATA)
        wdata <= hwdata[15:0];
      if ({24'h0, ap_addr} == `REG_CTRL)
        ctrl <= {30'h0, hwdata[1:0]};
    end
  end

  // Bus cycle engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= st_wake;
      op <= op_read;
      cnt <= 16'h0;
      rdata <= 16'h0;
      done <= 1'h0;
    end
    else
    begin
      unique case (state)
        st_idle:
        begin
          if (!ctrl[`CTRL_RESET_PIN])
          begin
            done <= 1'h0;
          end
          else if (!fl_reset_powerdown_n)
          begin
            // [R16] wake delay
            state <= st_wake;
            cnt <= 16'h0;
          end
          else if (ap_valid && ap_write && {24'h0, ap_addr} == `REG_CMD)
          begin
            // [R1] command cycle
            op <= op_e'(hwdata[1:0]);
            done <= 1'h0;
            cnt <= 16'h0;
            state <= (hwdata[1:0] == 2'h2) ? st_poll : st_setup;
          end
        end
        st_wake:
        begin
          cnt <= cnt + 16'h1;
          if (cnt >= 16'(WAKE_CNT))
            state <= st_idle;
        end
        st_setup:
        begin
          cnt <= 16'h0;
          state <= st_strobe;
        end
        st_strobe:
        begin
          cnt <= cnt + 16'h1;
          if (cnt >= 16'(CYCLE_CNT))
          begin
            if (op == op_read)
              rdata <= dq_level[0];
            state <= st_hold;
          end
        end
        st_hold:
        begin
          done <= 1'h1;
          state <= st_idle;
        end
        st_poll:
        begin
          // [R23] wait for level-mode ready
          if (sts_level)
          begin
            done <= 1'h1;
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Pin drive; both chip selects asserted together
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fl_addr <= 21'h0;
      fl_dq_out <= 16'h0;
      fl_dq_oe <= 1'h0;
      fl_chip_select_first_n <= 1'h1;
      fl_chip_select_second_n <= 1'h1;
      fl_write_n <= 1'h1;
      fl_output_n <= 1'h1;
      fl_reset_powerdown_n <= 1'h0;
      fl_byte_n <= 1'h1;
    end
    else
    begin
      // [R14] power-down pin from control
      fl_reset_powerdown_n <= ctrl[`CTRL_RESET_PIN];
      // [R19] bus width select
      fl_byte_n <= ~ctrl[`CTRL_BYTE_MODE];
      fl_addr <= addr;
      fl_dq_out <= wdata;
      // [R21] select only in cycle
      fl_chip_select_first_n <= !(state == st_strobe);
      fl_chip_select_second_n <= !(state == st_strobe);
      // [R22] data held across strobe
      fl_dq_oe <= (state == st_setup || state == st_strobe ||
        state == st_hold) && op == op_write;
      // [R7] lock commands as data
      // [R13] pin configuration as data
      fl_write_n <= !(state == st_strobe && op == op_write);
      fl_output_n <= !(state == st_strobe && op == op_read);
    end
  end
endmodule : flash_host_ctrl

// [src/flash_ctrl_map.svh]
// Offsets, fields, resets and timing counts of the flash host controller
// Function
// [R1] Host starts every erase, write or lock by a command sequence.
// [R2] Device write state machine runs erase, write and lock algorithms alone.
// [R3] Array is thirty-two independent 64 KB blocks.
// [R4] During erase suspend, other blocks may be read or written.
// [R5] During write suspend, other array locations may be read.
// [R6] Lock bit with write-protect pin blocks erase and write of a block.
// [R7] Host sets one lock bit or clears all by commands.
// [R8] Device status register reports completion of each operation.
// [R9] Status pin starts in ready/busy level mode after reset.
// [R10] In level mode the status pin is low while busy.
// [R11] In level mode the status pin floats when ready, suspended or down.
// [R12] Three more status pin modes give interrupt pulses.
// [R13] Host selects status pin mode by configuration command.
// [R14] Reset pin low gives deep power-down and inhibits writes.
// [R15] Reset pin low resets write state machine and clears status.
// [R16] Host waits wake and output delays after reset pin rises.
// [R17] Program supply below lockout threshold refuses erase and write.
// [R18] Multi writes stage in a page buffer of two 32-byte planes.
// [R19] Data interface is 8 or 16 bits wide.
// [R20] Upper data byte unused for status reads; floats in 8-bit mode.
// [R21] Device selected only while both chip selects are low.
// [R22] Device latches address and data during a write cycle.
// [R23] Host confirms previous operation finished before issuing a new one.
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

`define REG_CMD 32'h0000_0000
`define REG_ADDR 32'h0000_0004
`define REG_WDATA 32'h0000_0008
`define REG_RDATA 32'h0000_000c
`define REG_STAT 32'h0000_0010
`define REG_CTRL 32'h0000_0014

`define STAT_BUSY 0
`define STAT_PIN_READY 1
`define STAT_STS 2
`define STAT_DONE 3
`define STAT_WAKE 4

`define CTRL_RESET_PIN 0
`define CTRL_BYTE_MODE 1
`define CTRL_RESET_VAL 32'h0000_0001

`define CLK_NS 50
`define CYCLE_NS 100
`define CYCLE_CNT ((`CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_NS 1000
`define WAKE_CNT ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [src/flash_ctrl_pkg.sv]
// Types of the flash host controller
package flash_ctrl_pkg;
  typedef enum logic [1:0] {
    op_read,
    op_write,
    op_wait_ready
  } op_e;
  typedef logic [31:0] word_t;
endpackage : flash_ctrl_pkg

// [src/pin_sync.sv]
// Three-stage pin synchroniser, change accepted when stages two and three agree
module pin_sync
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);
  logic [2:0] stage;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage <= 3'h7;
    end
    else
    begin
      stage <= {stage[1:0], pin};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level <= 1'h1;
    end
    else if (stage[1] == stage[2])
    begin
      level <= stage[2];
    end
  end
endmodule : pin_sync

// [testbench/flash_ctrl_asserts.sv]
// Port-level checks of the flash host controller
module flash_ctrl_asserts
#(
  parameter int CYCLE_CNT = 2
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [20:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_dq_oe,
  input wire logic fl_chip_select_first_n,
  input wire logic fl_chip_select_second_n,
  input wire logic fl_write_n,
  input wire logic fl_output_n,
  input wire logic fl_reset_powerdown_n
);
  logic [7:0] low_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_cnt <= 8'h00;
    else if (!fl_write_n)
      low_cnt <= low_cnt + 8'h01;
    else
      low_cnt <= 8'h00;
  end
  sequence strobe_start;
    $fell(fl_write_n);
  endsequence
  sequence strobe_held;
    !fl_write_n ##1 !fl_write_n;
  endsequence
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  select_pair_a: assert property
    (fl_chip_select_first_n == fl_chip_select_second_n)
    else $error("chip selects differ");
  strobe_select_a: assert property
    (!fl_write_n || !fl_output_n |-> !fl_chip_select_first_n)
    else $error("strobe without select");
  one_strobe_a: assert property (fl_write_n || fl_output_n)
    else $error("both strobes low");
  write_drive_a: assert property (!fl_write_n |-> fl_dq_oe)
    else $error("write strobe without data drive");
  write_setup_a: assert property
    (strobe_start |-> $past(fl_dq_oe) ##0 strobe_held)
    else $error("write strobe setup or hold wrong");
  strobe_len_a: assert property
    ($rose(fl_write_n) |-> low_cnt == CYCLE_CNT + 1)
    else $error("write strobe length wrong");
  write_stable_a: assert property
    (!fl_write_n && $past(!fl_write_n) |->
      $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved in strobe");
  down_quiet_a: assert property
    (!fl_reset_powerdown_n |-> fl_write_n && fl_output_n)
    else $error("strobe while reset pin low");
endmodule : flash_ctrl_asserts

bind flash_host_ctrl flash_ctrl_asserts #(.CYCLE_CNT(CYCLE_CNT)) u_chk
  (.hclk, .hresetn, .hreadyout, .hresp, .fl_addr, .fl_dq_out, .fl_dq_oe,
   .fl_chip_select_first_n, .fl_chip_select_second_n, .fl_write_n,
   .fl_output_n, .fl_reset_powerdown_n);

// [testbench/flash_dev_model.sv]
// Behavioural model of the flash device at the far side
module flash_dev_model
(
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_w,
  input wire logic ce0_n,
  input wire logic ce1_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rp_n,
  input wire logic byte_n,
  output logic [15:0] dq_r,
  output logic sts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:63];
  logic [15:0] last = 16'h0000;
  logic [15:0] d_lat;
  logic [5:0] a_lat;
  logic [4:0] blk_lat;
  logic [31:0] lock_bit = 32'h0;
  logic supply_ok = 1'b1;
  logic pend = 1'b0;
  logic busy = 1'b0;
  logic [15:0] rd_word;
  wire sel = !ce0_n && !ce1_n && rp_n;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hffff;
  end
  // latch in cycle, block from top bits
  always @*
  begin
    if (sel && !we_n)
    begin
      a_lat = addr[5:0];
      blk_lat = addr[20:16];
      d_lat = dq_w;
      pend = 1'b1;
    end
  end
  // locked block or low supply refuses
  always @(posedge we_n)
  begin
    if (pend && rp_n && supply_ok && !lock_bit[blk_lat])
    begin
      mem[a_lat] = d_lat;
      busy = 1'b1;
    end
    pend = 1'b0;
  end
  always @(posedge busy) #2000 busy = 1'b0;
  always @(negedge rp_n) busy = 1'b0;
  always @(posedge oe_n) last = mem[addr[5:0]];
  // upper byte pulled high in byte mode
  assign rd_word = byte_n ? mem[addr[5:0]] : {8'hff, mem[addr[5:0]][7:0]};
  assign dq_r = (sel && !oe_n && we_n) ? rd_word : ~last;
  assign sts = (busy && rp_n) ? 1'b0 : 1'b1;
endmodule : flash_dev_model

// [testbench/tb.sv]
// Register-level testbench of the flash host controller
`include "flash_ctrl_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  word_t hrdata;
  word_t rd;
  logic hreadyout, hresp, fl_dq_oe, cs0_n, cs1_n, we_n, oe_n, rp_n, byte_n;
  logic sts;
  logic [20:0] fl_addr;
  logic [15:0] dq_o, dq_i;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  flash_host_ctrl #(.CYCLE_CNT(2), .WAKE_CNT(20)) DUT (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fl_addr(fl_addr), .fl_dq_out(dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(dq_i), .fl_chip_select_first_n(cs0_n),
    .fl_chip_select_second_n(cs1_n), .fl_write_n(we_n),
    .fl_output_n(oe_n), .fl_reset_powerdown_n(rp_n), .fl_byte_n(byte_n),
    .fl_status_output_pin(sts));
  flash_dev_model u_dev (.addr(fl_addr), .dq_w(dq_o), .ce0_n(cs0_n),
    .ce1_n(cs1_n), .we_n(we_n), .oe_n(oe_n), .rp_n(rp_n), .dq_r(dq_i),
    .sts(sts), .byte_n(byte_n));
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  task automatic bus(input logic w, input word_t a, input word_t d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic check(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_stat(input int b, input logic v);
    for (int i = 0; i < 300 && rd[b] !== v; i++) bus(0, `REG_STAT, 0);
    check(word_t'(rd[b]), word_t'(v));
  endtask : wait_stat
  task automatic op(input word_t c, input word_t a, input word_t d);
    bus(1, `REG_ADDR, a);
    bus(1, `REG_WDATA, d);
    bus(1, `REG_CMD, c);
    bus(0, `REG_STAT, 0);
    wait_stat(0, 1'b0);
    check(word_t'(rd[3]), 32'h1);
  endtask : op
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `REG_CTRL, 0);
    check(rd, `CTRL_RESET_VAL);
    check(word_t'(byte_n), 32'h1);
    bus(0, `REG_STAT, 0);
    wait_stat(`STAT_BUSY, 1'b0);
    check(word_t'(rd[`STAT_WAKE]), 32'h1);
    $display("test reset done");
    op(1, 32'h10, 32'h00a5);
    bus(0, `REG_STAT, 0);
    wait_stat(`STAT_STS, 1'b0);
    op(2, 0, 0);
    bus(0, `REG_STAT, 0);
    check(word_t'(rd[`STAT_STS]), 32'h1);
    op(1, 32'h11, 32'h5a3c);
    op(2, 0, 0);
    op(0, 32'h10, 0);
    bus(0, `REG_RDATA, 0);
    check(rd, 32'h00a5);
    op(0, 32'h11, 0);
    bus(0, `REG_RDATA, 0);
    check(rd, 32'h5a3c);
    $display("test write read done");
    bus(1, `REG_CTRL, 0);
    bus(1, `REG_ADDR, 32'h12);
    bus(1, `REG_WDATA, 32'h1234);
    bus(1, `REG_CMD, 1);
    bus(0, `REG_STAT, 0);
    check(rd & 32'h0000_0019, 32'h0);
    bus(1, `REG_CTRL, 1);
    bus(0, `REG_STAT, 0);
    wait_stat(`STAT_BUSY, 1'b1);
    wait_stat(`STAT_BUSY, 1'b0);
    check(word_t'(rd[`STAT_WAKE]), 32'h1);
    op(0, 32'h12, 0);
    bus(0, `REG_RDATA, 0);
    check(rd, 32'hffff);
    $display("test power down done");
    bus(1, `REG_CTRL, 3);
    bus(0, `REG_CTRL, 0);
    check(rd, 32'h3);
    check(word_t'(byte_n), 32'h0);
    op(0, 32'h10, 0);
    bus(0, `REG_RDATA, 0);
    check(rd, 32'hffa5);
    $display("test byte mode done");
    test_done();
  end
endmodule : tb
